/* File: logic/sbm_pkg.sv */
// shared constants, types and decode helpers for the system bus and memory access block
package sbm_pkg;

   // ---------------------------------------------
   // address map
   // ---------------------------------------------
   localparam int ADDR_W = 24;
   localparam int unsigned RAM_BASE = 32'h0000_0000;
   localparam int unsigned RAM_UNIT = 32'h0000_0400;
   localparam int unsigned DEBUG_BYTES = 32'h0000_0040;
   localparam int unsigned PERI_BASE = 32'h0000_4000;
   localparam int unsigned PERI_BYTES = 32'h0000_2000;
   localparam int unsigned SYSCTL_BYTES = 32'h0000_0020;
   localparam int unsigned DRAM_BASE = 32'h0000_7000;
   localparam int unsigned DRAM_BYTES = 32'h0000_0240;
   localparam int unsigned FLASH_BASE = 32'h0000_8000;
   localparam int unsigned CORE_BASE = 32'h00ff_fc00;
   localparam int unsigned SPACE_BYTES = 32'h0100_0000;

   // ---------------------------------------------
   // reset values and fills
   // ---------------------------------------------
   localparam logic [23:0] VEC_BASE_RST = 24'h00_8000;
   localparam logic [1:0] FLASH_WAIT_RST = 2'h3;
   localparam logic [2:0] RAM_LIM_RST = 3'h3;
   localparam logic [31:0] RSVD_FILL = 32'h0000_0000;
   localparam logic [7:0] TOP_ZERO = 8'h00;

   typedef enum logic [2:0] {
      RG_RAM = 3'b000,
      RG_PERI = 3'b001,
      RG_DRAM = 3'b010,
      RG_FLASH = 3'b011,
      RG_CORE = 3'b100,
      RG_RSVD = 3'b101
   } sbm_region_t;

   // log2 of a byte count: access size and region width share it
   typedef enum logic [1:0] {
      SZ_8 = 2'b00,
      SZ_16 = 2'b01,
      SZ_32 = 2'b10
   } sbm_size_t;

   function automatic sbm_size_t sbm_region_width(input sbm_region_t r);
      case (r)
         RG_RAM: return SZ_32;
         RG_CORE: return SZ_32;
         RG_RSVD: return SZ_32;
         default: return SZ_16;
      endcase
   endfunction

   function automatic logic [3:0] sbm_lane_mask(input sbm_size_t s);
      case (s)
         SZ_8: return 4'h1;
         SZ_16: return 4'h3;
         default: return 4'hf;
      endcase
   endfunction

   // fetch must wait behind data on a shared region
   function automatic logic sbm_conflict(input sbm_region_t f, input sbm_region_t d);
      logic f_ram;
      logic d_ram;
      f_ram = (f == RG_RAM) || (f == RG_DRAM);
      d_ram = (d == RG_RAM) || (d == RG_DRAM);
      return ((f == RG_FLASH) && ((d == RG_FLASH) || (d == RG_DRAM))) || (f_ram && d_ram);
   endfunction

endpackage

/* File: logic/sbm_dec_if.sv */
// carrier between the bus engine and its address decoder
`timescale 1ns/100ps
interface sbm_dec_if;
   import sbm_pkg::*;
   logic [23:0] addr;
   sbm_size_t size;
   logic [2:0] ram_lim;
   sbm_region_t region;
   sbm_size_t wlog;
   logic [1:0] beats_m1;
   logic sysctl;
   modport dec (input addr, input size, input ram_lim, output region, output wlog, output beats_m1,
      output sysctl);
   modport user (output addr, output size, output ram_lim, input region, input wlog, input beats_m1,
      input sysctl);
endinterface

/* File: logic/sbm_decode.sv */
// address decoder: region, region width and bus cycle count of one access
`timescale 1ns/100ps
module sbm_decode
   import sbm_pkg::*;
#(
   parameter int RAM_BYTES = 4096,
   parameter int FLASH_BYTES = 65536
)
(
   sbm_dec_if.dec d
);

   int unsigned a;
   int unsigned lim;

   always_comb
   begin
      a = 32'(d.addr);
      // usable ram grows in 1K steps, never past what is built
      lim = (32'(d.ram_lim) + 1) * RAM_UNIT;
      if (lim > RAM_BYTES)
      begin
         lim = RAM_BYTES;
      end
      if (a < RAM_BASE + lim)
      begin
         d.region = RG_RAM;
      end
      else if ((a >= PERI_BASE) && (a < PERI_BASE + PERI_BYTES))
      begin
         d.region = RG_PERI;
      end
      else if ((a >= DRAM_BASE) && (a < DRAM_BASE + DRAM_BYTES))
      begin
         d.region = RG_DRAM;
      end
      else if ((a >= FLASH_BASE) && (a < FLASH_BASE + FLASH_BYTES))
      begin
         d.region = RG_FLASH;
      end
      else if (a >= CORE_BASE)
      begin
         d.region = RG_CORE;
      end
      else
      begin
         d.region = RG_RSVD;
      end
      d.wlog = sbm_region_width(d.region);
      if (d.size > d.wlog)
      begin
         d.beats_m1 = 2'((1 << (d.size - d.wlog)) - 1);
      end
      else
      begin
         d.beats_m1 = 2'h0;
      end
      d.sysctl = (a >= PERI_BASE) && (a < PERI_BASE + SYSCTL_BYTES);
   end

endmodule // sbm_decode

/* File: logic/sbm_bus.sv */
// system bus engine: data access splitting, fetch arbitration, flash waits
`timescale 1ns/100ps
// Behaviour
// [RULE_01] Decode one shared 24-bit, 16M-byte space for fetch and data.
// [RULE_02] One bus cycle equals one system clock period; all transfers on that clock.
// [RULE_03] Bus cycles per access are access size over region width, at least one.
// [RULE_04] Peripheral area takes 8, 16 and 32-bit accesses, split to its width.
// [RULE_05] Every memory and register region completes a 16-bit access in one cycle; flash reads here add the wait field's cycles.
// [RULE_06] A 32-bit write from a 24-bit register stores zero in the top byte.
// [RULE_07] A 32-bit read into a 24-bit register drops the top byte.
// [RULE_08] Interrupt stacking moves status byte on top of 24-bit return address.
// [RULE_09] Fetch and data run in parallel, but flash fetch waits for flash data.
// [RULE_10] Flash fetch also waits behind data to the display RAM.
// [RULE_11] RAM or display RAM fetch waits behind data to either of them.
// [RULE_12] A held fetch is stretched by exactly the data access bus cycles.
// [RULE_13] Vector table base defaults to flash start after reset.
// [RULE_14] Flash read cycle count follows a 2-bit wait field chosen by software.
// [RULE_15] A 3-bit size field limits RAM; beyond it acts as reserved.
// [RULE_16] With debugging, software avoids the top 64 bytes of RAM.
// [RULE_17] Peripheral area spans 8K bytes, 16 bits wide.
// [RULE_18] Display RAM holds 576 bytes, 16 bits wide, spare bytes usable.
// [RULE_19] Top 1K bytes decode as core I/O, 32 bits wide.
// [RULE_20] Writes to system control registers are blocked until protection is released.
// [RULE_21] Reserved accesses take one cycle, read a fill value, write nothing.
// [RULE_22] Wait and RAM size fields act from the next access; reset restores them. Here a new wait value also reaches later beats of a running flash read.
module sbm_bus
   import sbm_pkg::*;
#(
   parameter int RAM_BYTES = 4096,
   parameter int FLASH_BYTES = 65536
)
(
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [1:0] FLASH_READ_WAIT_SEL,
   input wire logic [2:0] RAM_SIZE_LIMIT,
   input wire logic PROTECT_RELEASE,
   input wire logic [7:0] PROCESSOR_STATUS_WORD,
   input wire logic D_REQ,
   input wire logic D_WE,
   input wire logic [1:0] D_SIZE,
   input wire logic D_STACK,
   input wire logic [23:0] D_ADDR,
   input wire logic [31:0] D_WDATA,
   output logic D_ACK,
   output logic [31:0] D_RDATA,
   input wire logic F_REQ,
   input wire logic [23:0] F_ADDR,
   output logic F_ACK,
   output logic [15:0] F_RDATA,
   output logic DM_REQ,
   output logic DM_WE,
   output logic [23:0] DM_ADDR,
   output logic [2:0] DM_REGION,
   output logic [3:0] DM_BE,
   output logic [31:0] DM_WDATA,
   input wire logic [31:0] DM_RDATA,
   output logic FM_REQ,
   output logic [23:0] FM_ADDR,
   output logic [2:0] FM_REGION,
   input wire logic [15:0] FM_RDATA,
   output logic [23:0] VECTOR_BASE
);

   generate
      if ((RAM_BYTES < 1024) || (RAM_BYTES > 8192) || (FLASH_BYTES > 32'h00ff_7c00))
      begin : g_bad_size
         $error("sbm_bus: memory size outside the decodable map");
      end
   endgenerate

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_RUN = 2'b01,
      DS_RSVD = 2'b10
   } sbm_dstate_t;

   typedef enum logic [1:0] {
      FS_IDLE = 2'b00,
      FS_RUN = 2'b01,
      FS_RSVD = 2'b10
   } sbm_fstate_t;

   // ---------------------------------------------
   // configuration taken at the clock, reset to defaults
   // ---------------------------------------------
   logic [1:0] flash_read_cycle_reg;
   logic [2:0] ram_size_reg;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         flash_read_cycle_reg <= FLASH_WAIT_RST; // RULE_22
         ram_size_reg <= RAM_LIM_RST;
      end
      else
      begin
         flash_read_cycle_reg <= FLASH_READ_WAIT_SEL; // RULE_14
         ram_size_reg <= RAM_SIZE_LIMIT; // RULE_15
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         VECTOR_BASE <= VEC_BASE_RST; // RULE_13
      end
      else
      begin
         VECTOR_BASE <= VEC_BASE_RST;
      end
   end

   // ---------------------------------------------
   // decoders
   // ---------------------------------------------
   sbm_dec_if ddec ();
   sbm_dec_if fdec ();

   assign ddec.addr = D_ADDR; // RULE_01
   assign ddec.size = sbm_size_t'(D_SIZE);
   assign ddec.ram_lim = ram_size_reg;
   assign fdec.addr = F_ADDR;
   assign fdec.size = SZ_16;
   assign fdec.ram_lim = ram_size_reg;

   sbm_decode #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_ddec (.d(ddec.dec));
   sbm_decode #(.RAM_BYTES(RAM_BYTES), .FLASH_BYTES(FLASH_BYTES)) u_fdec (.d(fdec.dec));

   // ---------------------------------------------
   // arbitration
   // ---------------------------------------------
   sbm_dstate_t d_state;
   sbm_fstate_t f_state;
   sbm_region_t d_region;
   sbm_region_t f_region;
   logic d_go;
   logic f_go;
   logic d_busy_clash;
   logic [1:0] d_beat;
   logic [1:0] d_last;
   logic [1:0] d_wait;

   // data wins a tie; a running fetch holds off a clashing data start
   assign d_go = D_REQ && (d_state == DS_IDLE) && !((f_state == FS_RUN) && sbm_conflict(f_region, ddec.region));
   // data frees the bus on the edge that ends its last beat, so a held fetch starts there
   assign d_busy_clash = ((d_state == DS_RUN) && !((d_wait == 2'h0) && (d_beat == d_last)) &&
      sbm_conflict(fdec.region, d_region)) ||
      (d_go && sbm_conflict(fdec.region, ddec.region)); // RULE_09 RULE_10 RULE_11
   // the fetch simply waits out every data cycle, so its stretch equals them
   assign f_go = F_REQ && (f_state == FS_IDLE) && !F_ACK && !d_busy_clash; // RULE_12

   // ---------------------------------------------
   // data engine
   // ---------------------------------------------
   sbm_size_t d_wlog;
   sbm_size_t d_size;
   logic d_we;
   logic d_stack;
   logic [7:0] d_psw;
   logic [31:0] d_wfull;
   logic [31:0] d_acc;
   logic [31:0] next_acc;
   logic [4:0] d_shamt;
   logic [31:0] beat_mask;
   logic [31:0] wfull_in;
   logic blocked;

   always_comb
   begin
      // 32-bit writes carry zero or, when stacking, the status byte on top
      wfull_in = D_WDATA;
      if (sbm_size_t'(D_SIZE) == SZ_32)
      begin
         wfull_in = {D_STACK ? PROCESSOR_STATUS_WORD : TOP_ZERO, D_WDATA[23:0]}; // RULE_06 RULE_08
      end
      beat_mask = {{8{DM_BE[3]}}, {8{DM_BE[2]}}, {8{DM_BE[1]}}, {8{DM_BE[0]}}};
      d_shamt = 5'(32'(d_beat) << (32'(d_wlog) + 3));
      next_acc = d_acc | ((DM_RDATA & beat_mask) << d_shamt);
   end

   assign blocked = D_WE && ddec.sysctl && !PROTECT_RELEASE; // RULE_20

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         d_state <= DS_IDLE;
         d_region <= RG_RSVD;
         d_wlog <= SZ_8;
         d_size <= SZ_8;
         d_we <= 1'b0;
         d_stack <= 1'b0;
         d_psw <= TOP_ZERO;
         d_beat <= 2'h0;
         d_last <= 2'h0;
         d_wait <= 2'h0;
         d_wfull <= RSVD_FILL;
         d_acc <= RSVD_FILL;
      end
      else
      begin
         case (d_state)
            DS_IDLE:
            begin
               if (d_go)
               begin
                  d_region <= ddec.region;
                  d_wlog <= ddec.wlog;
                  d_size <= sbm_size_t'(D_SIZE);
                  d_we <= D_WE;
                  d_stack <= D_STACK;
                  d_psw <= PROCESSOR_STATUS_WORD;
                  d_beat <= 2'h0;
                  d_last <= ddec.beats_m1; // RULE_03 RULE_04
                  d_wait <= (ddec.region == RG_FLASH && !D_WE) ? flash_read_cycle_reg : 2'h0; // RULE_14
                  d_wfull <= wfull_in;
                  d_acc <= RSVD_FILL;
                  d_state <= (ddec.region == RG_RSVD) ? DS_RSVD : DS_RUN; // RULE_21
               end
            end
            DS_RUN:
            begin
               if (d_wait != 2'h0)
               begin
                  d_wait <= d_wait - 2'h1;
               end
               else
               begin
                  d_acc <= next_acc;
                  if (d_beat == d_last)
                  begin
                     d_state <= DS_IDLE;
                  end
                  else
                  begin
                     d_beat <= d_beat + 2'h1;
                     d_wait <= (d_region == RG_FLASH && !d_we) ? flash_read_cycle_reg : 2'h0;
                  end
               end
            end
            DS_RSVD:
            begin
               d_state <= DS_IDLE;
            end
            default:
            begin
               d_state <= DS_IDLE;
            end
         endcase
      end
   end

   // memory side of the data engine, one beat of region width at a time
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         DM_REQ <= 1'b0;
         DM_WE <= 1'b0;
         DM_ADDR <= '0;
         DM_REGION <= RG_RSVD;
         DM_BE <= 4'h0;
         DM_WDATA <= RSVD_FILL;
      end
      else if (d_state == DS_IDLE && d_go && ddec.region != RG_RSVD)
      begin
         DM_REQ <= 1'b1; // RULE_02
         DM_WE <= D_WE && !blocked;
         DM_ADDR <= D_ADDR;
         DM_REGION <= ddec.region; // RULE_17 RULE_18 RULE_19
         DM_BE <= sbm_lane_mask((sbm_size_t'(D_SIZE) < ddec.wlog) ? sbm_size_t'(D_SIZE) : ddec.wlog);
         DM_WDATA <= wfull_in;
      end
      else if (d_state == DS_RUN && d_wait == 2'h0)
      begin
         if (d_beat == d_last)
         begin
            DM_REQ <= 1'b0;
            DM_WE <= 1'b0;
         end
         else
         begin
            DM_ADDR <= DM_ADDR + 24'(1 << d_wlog);
            DM_WDATA <= d_wfull >> 5'(32'(d_beat + 2'h1) << (32'(d_wlog) + 3));
         end
      end
   end

   // answer to the core
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         D_ACK <= 1'b0;
         D_RDATA <= RSVD_FILL;
      end
      else
      begin
         D_ACK <= 1'b0;
         if (d_state == DS_RSVD)
         begin
            D_ACK <= 1'b1;
            D_RDATA <= RSVD_FILL; // RULE_21
         end
         else if (d_state == DS_RUN && d_wait == 2'h0 && d_beat == d_last)
         begin
            D_ACK <= 1'b1;
            D_RDATA <= next_acc;
            if (d_size == SZ_32 && !d_stack)
            begin
               D_RDATA <= {TOP_ZERO, next_acc[23:0]}; // RULE_07
            end
         end
      end
   end

   // ---------------------------------------------
   // fetch engine, 16-bit instructions, one beat
   // ---------------------------------------------
   logic [1:0] f_wait;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         f_state <= FS_IDLE;
         f_region <= RG_RSVD;
         f_wait <= 2'h0;
         FM_REQ <= 1'b0;
         FM_ADDR <= '0;
         FM_REGION <= RG_RSVD;
         F_ACK <= 1'b0;
         F_RDATA <= '0;
      end
      else
      begin
         F_ACK <= 1'b0;
         case (f_state)
            FS_IDLE:
            begin
               if (f_go)
               begin
                  f_region <= fdec.region;
                  f_wait <= (fdec.region == RG_FLASH) ? flash_read_cycle_reg : 2'h0; // RULE_14
                  FM_REQ <= (fdec.region != RG_RSVD);
                  FM_ADDR <= F_ADDR;
                  FM_REGION <= fdec.region;
                  f_state <= (fdec.region == RG_RSVD) ? FS_RSVD : FS_RUN;
               end
            end
            FS_RUN:
            begin
               if (f_wait != 2'h0)
               begin
                  f_wait <= f_wait - 2'h1;
               end
               else
               begin
                  FM_REQ <= 1'b0;
                  F_ACK <= 1'b1;
                  F_RDATA <= FM_RDATA;
                  f_state <= FS_IDLE;
               end
            end
            FS_RSVD:
            begin
               F_ACK <= 1'b1;
               F_RDATA <= RSVD_FILL[15:0]; // RULE_21
               f_state <= FS_IDLE;
            end
            default:
            begin
               f_state <= FS_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);

   ack_pulse_a: assert property (D_ACK |=> !D_ACK) // RULE_02
      else $error("data answer lasted more than one cycle");
   peri_split_a: assert property (d_go && D_WE && D_SIZE == SZ_32 && ddec.region == RG_PERI |=> // RULE_04
      DM_REQ ##1 DM_REQ ##1 D_ACK)
      else $error("32-bit peripheral write did not take two bus cycles");
   ram_word_a: assert property (d_go && D_SIZE == SZ_32 && ddec.region == RG_RAM |=> DM_REQ ##1 D_ACK) // RULE_03
      else $error("32-bit RAM access did not take one bus cycle");
   half_one_a: assert property (d_go && D_WE && D_SIZE == SZ_16 && ddec.region != RG_RSVD |=> ##1 D_ACK) // RULE_05
      else $error("16-bit access took more than one bus cycle");
   top_zero_a: assert property (DM_REQ && DM_WE && d_size == SZ_32 && !d_stack && d_wlog == SZ_32 |-> // RULE_06
      DM_WDATA[31:24] == TOP_ZERO)
      else $error("32-bit write stored a nonzero top byte");
   read_trunc_a: assert property (d_state == DS_RUN && !d_we && d_size == SZ_32 && !d_stack ##1 D_ACK |-> // RULE_07
      D_RDATA[31:24] == TOP_ZERO)
      else $error("32-bit read returned a top byte");
   stack_psw_a: assert property (d_go && D_WE && D_STACK && D_SIZE == SZ_32 && ddec.region == RG_RAM |=> // RULE_08
      DM_REQ && DM_WDATA[31:24] == $past(PROCESSOR_STATUS_WORD))
      else $error("stacked word lost the status byte");
   // a clashing pair may hand over on one edge but never share a bus cycle
   fetch_hold_a: assert property (FM_REQ && DM_REQ |-> // RULE_10
      !sbm_conflict(sbm_region_t'(FM_REGION), sbm_region_t'(DM_REGION)))
      else $error("fetch ran beside a clashing data access");
   vec_base_a: assert property (VECTOR_BASE == VEC_BASE_RST) // RULE_13
      else $error("vector base left its reset value");
   flash_wait_a: assert property ($rose(DM_REQ) && DM_REGION == RG_FLASH && !DM_WE && d_size == SZ_16 && // RULE_14
      flash_read_cycle_reg == 2'h3 |-> DM_REQ [*4] ##1 !DM_REQ)
      else $error("flash read wait count wrong");
   protect_a: assert property (d_go && blocked |=> !DM_WE) // RULE_20
      else $error("protected write reached memory");
   rsvd_quiet_a: assert property (d_go && ddec.region == RG_RSVD |=> !DM_REQ ##1 D_ACK) // RULE_21
      else $error("reserved access not answered in one cycle");

   split_c: cover property (d_go && D_SIZE == SZ_32 && ddec.region == RG_PERI ##3 D_ACK);
   clash_c: cover property (F_REQ && d_busy_clash ##1 F_REQ && d_busy_clash ##1 f_go);
   flash_c: cover property (f_go && fdec.region == RG_FLASH ##[1:4] F_ACK);

endmodule // sbm_bus

/* File: testbench/sbm_mem_model.sv */
// behavioural memory behind the bus engine, shared by data and fetch ports
`timescale 1ns/100ps
module sbm_mem_model
   import sbm_pkg::*;
(
   input wire logic clk,
   input wire logic dm_req,
   input wire logic dm_we,
   input wire logic [23:0] dm_addr,
   input wire logic [3:0] dm_be,
   input wire logic [31:0] dm_wdata,
   output logic [31:0] dm_rdata,
   input wire logic fm_req,
   input wire logic [23:0] fm_addr,
   output logic [15:0] fm_rdata
);
   logic [7:0] mem [int];
   // released lines toggle so a stale value never passes for data
   logic [31:0] idle = 32'h5a5a_a5a5;

   function automatic logic [7:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 8'(a) ^ 8'h3c;
   endfunction

   always @(posedge clk)
   begin
      idle <= ~idle;
      if (dm_req && dm_we)
         for (int i = 0; i < 4; i++)
            if (dm_be[i])
               mem[int'(dm_addr) + i] = dm_wdata[8*i +: 8];
   end

   assign dm_rdata = dm_req ? {rd(int'(dm_addr) + 3), rd(int'(dm_addr) + 2), rd(int'(dm_addr) + 1),
      rd(int'(dm_addr))} : idle;
   assign fm_rdata = fm_req ? {rd(int'(fm_addr) + 1), rd(int'(fm_addr))} : idle[15:0];
endmodule // sbm_mem_model

/* File: testbench/tb.sv */
// self-checking bench for the system bus engine
`timescale 1ns/100ps
module tb;
   import sbm_pkg::*;
   typedef struct {
      logic we;
      logic [1:0] sz;
      logic stk;
      logic pr;
      logic [1:0] w;
      logic [2:0] lim;
      logic [23:0] a;
      logic [31:0] wd;
      int cyc;
      logic chk;
      logic [31:0] exp;
   } sbm_tb_row_t;
   typedef struct {
      logic [23:0] fa;
      logic [23:0] da;
      logic [1:0] dsz;
      int fcyc;
   } sbm_tb_pair_t;

   logic clk;
   logic rst_n;
   logic [1:0] flash_read_wait_sel;
   logic [2:0] ram_size_limit;
   logic protect_release;
   logic [7:0] processor_status_word;
   logic d_req, d_we, d_stack, d_ack, f_req, f_ack, dm_req, dm_we, fm_req;
   logic [1:0] d_size;
   logic [23:0] d_addr, f_addr, dm_addr, fm_addr, vector_base;
   logic [31:0] d_wdata, d_rdata, dm_wdata, dm_rdata, rd;
   logic [3:0] dm_be;
   logic [15:0] f_rdata, fm_rdata, fd;
   int failures = 0;
   int num_checks = 0;
   int n;
   int nf;

   sbm_tb_row_t rows [24] = '{
      '{1,2,0,0,0,3,24'h100,32'hab12_3456,2,0,0},
      '{0,2,1,0,0,3,24'h100,0,2,1,32'h0012_3456},
      '{1,2,1,0,0,3,24'h104,32'h0065_4321,2,0,0},
      '{0,2,0,0,0,3,24'h104,0,2,1,32'h0065_4321},
      '{0,2,1,0,0,3,24'h104,0,2,1,32'hc565_4321},
      '{1,2,0,0,0,3,24'h4100,32'h1122_3344,3,0,0},
      '{0,2,0,0,0,3,24'h4100,0,3,1,32'h0022_3344},
      '{0,0,0,0,0,3,24'h4101,0,2,1,32'h33},
      '{1,1,0,0,0,3,24'h723e,32'hbeef,2,0,0},
      '{0,1,0,0,0,3,24'h723e,0,2,1,32'hbeef},
      '{0,1,0,0,0,3,24'h8000,0,2,0,0},
      '{0,1,0,0,3,3,24'h8000,0,5,0,0},
      '{0,2,0,0,2,3,24'h8000,0,7,0,0},
      '{1,2,0,0,0,3,24'hff_fc00,32'h00ab_cdef,2,0,0},
      '{0,2,0,0,0,3,24'hff_fc00,0,2,1,32'h00ab_cdef},
      '{0,2,0,0,0,3,24'h6000,0,2,1,0},
      '{1,2,0,0,0,3,24'h400,32'h0011_1111,2,0,0},
      '{1,2,0,0,0,0,24'h400,32'h0022_2222,2,0,0},
      '{0,2,0,0,0,0,24'h400,0,2,1,0},
      '{0,2,0,0,0,3,24'h400,0,2,1,32'h0011_1111},
      '{1,2,0,0,0,3,24'hfc0,32'h0033_3333,2,0,0},
      '{1,1,0,1,0,3,24'h4002,32'h1234,2,0,0},
      '{1,1,0,0,0,3,24'h4002,32'h5678,2,0,0},
      '{0,1,0,0,0,3,24'h4002,0,2,1,32'h1234}
   };
   sbm_tb_pair_t pairs [6] = '{
      '{24'h8000,24'h8100,2,4},
      '{24'h8000,24'h7000,2,4},
      '{24'h100,24'h7000,2,4},
      '{24'h7000,24'h200,1,3},
      '{24'h100,24'h4100,2,2},
      '{24'h8000,24'h200,2,2}
   };

   sbm_bus DUT (.CORE_CLK(clk), .RST_N(rst_n), .FLASH_READ_WAIT_SEL(flash_read_wait_sel),
      .RAM_SIZE_LIMIT(ram_size_limit), .PROTECT_RELEASE(protect_release),
      .PROCESSOR_STATUS_WORD(processor_status_word), .D_REQ(d_req), .D_WE(d_we), .D_SIZE(d_size),
      .D_STACK(d_stack), .D_ADDR(d_addr), .D_WDATA(d_wdata), .D_ACK(d_ack), .D_RDATA(d_rdata),
      .F_REQ(f_req), .F_ADDR(f_addr), .F_ACK(f_ack), .F_RDATA(f_rdata), .DM_REQ(dm_req), .DM_WE(dm_we),
      .DM_ADDR(dm_addr), .DM_REGION(), .DM_BE(dm_be), .DM_WDATA(dm_wdata), .DM_RDATA(dm_rdata),
      .FM_REQ(fm_req), .FM_ADDR(fm_addr), .FM_REGION(), .FM_RDATA(fm_rdata), .VECTOR_BASE(vector_base));

   sbm_mem_model mem (.clk(clk), .dm_req(dm_req), .dm_we(dm_we), .dm_addr(dm_addr), .dm_be(dm_be),
      .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .fm_req(fm_req), .fm_addr(fm_addr), .fm_rdata(fm_rdata));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h got %h", nm, e, g);
      end
   endtask

   task automatic cmp_n(input string nm, input int e, input int g);
      num_checks++;
      if (g != e)
      begin
         failures++;
         $display("[FAIL] %s expected %0d got %0d", nm, e, g);
      end
   endtask

   function automatic logic [31:0] mask(input logic [1:0] s);
      return s == 2'h0 ? 32'hff : (s == 2'h1 ? 32'hffff : 32'hffff_ffff);
   endfunction

   // config is registered, so it is set one edge ahead of the request
   task automatic setcfg(input logic [1:0] w, input logic [2:0] lim, input logic pr);
      @(posedge clk);
      #1;
      flash_read_wait_sel = w;
      ram_size_limit = lim;
      protect_release = pr;
   endtask

   task automatic dacc(input logic we, input logic [1:0] sz, input logic stk, input logic [23:0] a,
      input logic [31:0] wd, output int c, output logic [31:0] r);
      @(posedge clk);
      #1;
      {d_req, d_we, d_size, d_stack, d_addr, d_wdata} = {1'b1, we, sz, stk, a, wd};
      c = 0;
      do
      begin
         @(posedge clk);
         #1;
         c++;
      end
      while (d_ack !== 1'b1 && c < 50);
      r = d_rdata;
      d_req = 0;
   endtask

   task automatic facc(input logic [23:0] a, output int c, output logic [15:0] r);
      @(posedge clk);
      #1;
      f_req = 1;
      f_addr = a;
      c = 0;
      do
      begin
         @(posedge clk);
         #1;
         c++;
      end
      while (f_ack !== 1'b1 && c < 50);
      r = f_rdata;
      f_req = 0;
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // stimulus
   // ----------------------------------------
   initial
   begin
      clk = 0;
      forever #50 clk = ~clk;
   end

   initial
   begin
      #2_000_000;
      failures++;
      close_out();
   end

   initial
   begin
      {rst_n, d_req, d_we, d_stack, f_req, protect_release, d_size} = 0;
      {d_addr, d_wdata, f_addr} = 0;
      flash_read_wait_sel = 0;
      ram_size_limit = 3;
      processor_status_word = 8'hc5;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1;
      cmp("vector base", 32'h8000, {8'h0, vector_base});
      foreach (rows[i])
      begin
         setcfg(rows[i].w, rows[i].lim, rows[i].pr);
         dacc(rows[i].we, rows[i].sz, rows[i].stk, rows[i].a, rows[i].wd, n, rd);
         cmp_n("data cycles", rows[i].cyc, n);
         if (rows[i].chk)
            cmp("data read", rows[i].exp, rd & mask(rows[i].sz));
         $display("row %0d done", i);
      end
      setcfg(2'h0, 3'h3, 1'b0);
      foreach (pairs[i])
      begin
         fork
            dacc(1'b0, pairs[i].dsz, 1'b0, pairs[i].da, 32'h0, n, rd);
            facc(pairs[i].fa, nf, fd);
         join
         cmp_n("fetch cycles", pairs[i].fcyc, nf);
         $display("pair %0d done", i);
      end
      facc(24'h100, nf, fd);
      cmp_n("ram fetch cycles", 2, nf);
      cmp("ram fetch data", 32'h3456, {16'h0, fd});
      setcfg(2'h2, 3'h3, 1'b0);
      facc(24'h8000, nf, fd);
      cmp_n("flash fetch cycles", 4, nf);
      facc(24'h6000, nf, fd);
      cmp("reserved fetch", 32'h0, {16'h0, fd});
      $display("fetch tests done");
      @(posedge clk);
      #1;
      rst_n = 0;
      #1;
      cmp("ack in reset", 32'h0, {31'h0, d_ack});
      cmp("vector base", 32'h8000, {8'h0, vector_base});
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1;
      dacc(1'b0, 2'h2, 1'b0, 24'h100, 32'h0, n, rd);
      cmp("read after reset", 32'h0012_3456, rd);
      $display("reset test done");
      close_out();
   end
endmodule // tb
